// ==== rsf_rx_deliver.sv ====
// Receive delivery of decoded frames toward the host sublayer, plus reset service.
// Assumes the line decoder runs on rx_link_clk_i and flags starts at octet boundaries.
//
// Notes on behaviour
// - In checksum idle: activity low, check select high.
// - Data frame start: on rising edge raise activity, check select low, first bit out.
// - Status start from checksum idle: activity high, status flag low, first bit out.
// - During data, decoded bits shift out with clock tracking received timing.
// - Data pause after an octet lowers activity on a falling clock edge.
// - During data idle both activity and check select stay low.
// - Check sequence after data idle: activity and check select rise together.
// - New data octet after data idle raises activity and resumes data bits.
// - Checksum bits keep flowing with clock tracking received timing.
// - First status bit after checksum: status flag low on rising edge with bit.
// - Checksum pause after an octet lowers activity on a falling edge.
// - Further checksum octet after pause raises activity and resumes checksum bits.
// - Status complete: activity low and status flag high on one falling edge.
// - Further status octet after pause raises activity and resumes status bits.
// - Content is delivered in whole octets; changes only at octet boundaries.
// - Device answers a reset with reset indication, short or long duration.
// - Cycle start shown by high-to-low change of cycle select, not clock-tied.
`timescale 1ns/1ps
`default_nettype none
module rsf_rx_deliver
	import rsf_pkg::*;
#(
	parameter int RST_LONG_CYCLES = RST_LONG_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic rx_link_clk_i,
	input wire logic dec_bit_i,
	input wire logic dec_valid_i,
	input wire logic dec_frame_start_i,
	input wire logic dec_check_start_i,
	input wire logic dec_status_start_i,
	input wire logic dec_frame_end_i,
	input wire logic dec_cycle_start_i,
	input wire logic reset_request_out_i,
	input wire logic reset_long_sel_i,
	output logic receive_clock_o,
	output logic receive_data_line_o,
	output logic receive_activity_o,
	output logic receive_check_select_o,
	output logic receive_status_flag_o,
	output logic reset_indication_o,
	output logic receive_cycle_select_o
);
	// ---------------------------------------------------------------
	// Core domain: reset service
	// ---------------------------------------------------------------
	logic req_sync;
	logic long_sync;
	logic req_seen_r;
	logic req_rise;
	logic link_rst_src_r;
	logic [TMR_W-1:0] boot_cnt_r;
	logic [TMR_W-1:0] boot_cnt_nxt;
	logic [TMR_W-1:0] rst_len;
	rsf_tmr_if rst_tmr ();

	rsf_sync #(.RST_VAL(1'b0)) u_req_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i(reset_request_out_i),
		.q_o(req_sync)
	);

	rsf_sync #(.RST_VAL(1'b0)) u_long_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i(reset_long_sel_i),
		.q_o(long_sync)
	);

	// Request edge from the far party starts the indication pulse
	assign req_rise = req_sync && !req_seen_r;
	assign rst_len = long_sync ? TMR_W'(RST_LONG_CYCLES) : TMR_W'(RST_SHORT_CYC);
	assign rst_tmr.start = req_rise;
	assign rst_tmr.len = rst_len;
	assign reset_indication_o = rst_tmr.busy;
	// Stretch core reset so a slow or late link clock still sees it
	assign boot_cnt_nxt = (boot_cnt_r != '0) ? boot_cnt_r - 1'b1 : boot_cnt_r;

	rsf_pulse_timer u_rst_tmr (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.ctl(rst_tmr)
	);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			req_seen_r <= 1'b0;
			link_rst_src_r <= 1'b1;
			boot_cnt_r <= TMR_W'(RST_SHORT_CYC);
		end else begin
			req_seen_r <= req_sync;
			link_rst_src_r <= rst_tmr.busy || (boot_cnt_r != '0);
			boot_cnt_r <= boot_cnt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Core domain: cycle select pulse
	// ---------------------------------------------------------------
	logic cyc_tgl_r;
	logic cyc_sync;
	logic cyc_seen_r;
	logic cyc_evt;
	rsf_tmr_if cyc_tmr ();

	rsf_sync #(.RST_VAL(1'b0)) u_cyc_sync (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.d_i(cyc_tgl_r),
		.q_o(cyc_sync)
	);

	// Events are dropped while the link side is held in reset
	assign cyc_evt = (cyc_sync ^ cyc_seen_r) && !link_rst_src_r;
	assign cyc_tmr.start = cyc_evt;
	assign cyc_tmr.len = TMR_W'(CYC_LOW_CYC);
	// High-to-low change marks an identification or data cycle start
	assign receive_cycle_select_o = cyc_tmr.busy ? !CYC_SEL_IDLE : CYC_SEL_IDLE;

	rsf_pulse_timer u_cyc_tmr (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.ctl(cyc_tmr)
	);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cyc_seen_r <= 1'b0;
		end else begin
			cyc_seen_r <= cyc_sync;
		end
	end

	// ---------------------------------------------------------------
	// Link domain: reset crossing
	// ---------------------------------------------------------------
	logic link_rst;

	// Held in reset by core reset and by every reset indication
	rsf_sync #(.RST_VAL(1'b1)) u_link_rst_sync (
		.clk_i(rx_link_clk_i),
		.rst_i(1'b0),
		.d_i(link_rst_src_r),
		.q_o(link_rst)
	);

	// ---------------------------------------------------------------
	// Link domain: delivery state machine
	// ---------------------------------------------------------------
	rsf_state_t state_r;
	rsf_state_t state_nxt;
	logic [BIT_CNT_W-1:0] bit_cnt_r;
	logic [BIT_CNT_W-1:0] bit_cnt_nxt;
	logic at_bnd;
	logic take_bit;
	logic data_r;
	logic act_r;
	logic act_nxt;
	logic chk_r;
	logic chk_nxt;
	logic stat_low_r;
	logic stat_low_nxt;
	logic act_neg_r;
	logic stat_low_neg_r;

	assign at_bnd = (bit_cnt_r == BIT_CNT_BND);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_CRC_IDLE: begin
				if (dec_valid_i && dec_frame_start_i) begin
					state_nxt = ST_DATA_SEQ;
				end else if (dec_valid_i && dec_status_start_i) begin
					state_nxt = ST_CRC_STATUS;
				end else if (dec_valid_i && dec_check_start_i) begin
					state_nxt = ST_CRC_DATA;
				end
			end
			ST_DATA_SEQ: begin
				if (at_bnd && !dec_valid_i) begin
					state_nxt = ST_DATA_IDLE;
				end else if (at_bnd && dec_check_start_i) begin
					state_nxt = ST_CRC_DATA;
				end
			end
			ST_DATA_IDLE: begin
				if (dec_valid_i && dec_check_start_i) begin
					state_nxt = ST_CRC_DATA;
				end else if (dec_valid_i) begin
					state_nxt = ST_DATA_SEQ;
				end else if (dec_frame_end_i) begin
					state_nxt = ST_CRC_IDLE;
				end
			end
			ST_CRC_DATA: begin
				if (at_bnd && dec_valid_i && dec_status_start_i) begin
					state_nxt = ST_CRC_STATUS;
				end else if (at_bnd && !dec_valid_i) begin
					state_nxt = ST_CRC_IDLE;
				end
			end
			ST_CRC_STATUS: begin
				if (at_bnd && !dec_valid_i && dec_frame_end_i) begin
					state_nxt = ST_CRC_IDLE;
				end else if (at_bnd && !dec_valid_i) begin
					state_nxt = ST_STATUS_IDLE;
				end
			end
			ST_STATUS_IDLE: begin
				if (dec_valid_i) begin
					state_nxt = ST_CRC_STATUS;
				end else if (dec_frame_end_i) begin
					state_nxt = ST_CRC_IDLE;
				end
			end
			default: begin
				state_nxt = ST_CRC_IDLE;
			end
		endcase
	end

	// A bit is delivered when the next state is one that carries content and dec_valid_i is high
	assign act_nxt = (state_nxt == ST_DATA_SEQ) || (state_nxt == ST_CRC_DATA)
		|| (state_nxt == ST_CRC_STATUS);
	assign take_bit = act_nxt && dec_valid_i;
	assign bit_cnt_nxt = take_bit ? bit_cnt_r + 1'b1 : bit_cnt_r;
	assign chk_nxt = !((state_nxt == ST_DATA_SEQ) || (state_nxt == ST_DATA_IDLE));
	assign stat_low_nxt = (state_nxt == ST_CRC_STATUS) || (state_nxt == ST_STATUS_IDLE);

	always_ff @(posedge rx_link_clk_i) begin
		if (link_rst) begin
			state_r <= ST_CRC_IDLE;
			bit_cnt_r <= BIT_CNT_BND;
			act_r <= ACT_RST;
			chk_r <= CHK_SEL_RST;
			stat_low_r <= STAT_LOW_RST;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			act_r <= act_nxt;
			chk_r <= chk_nxt;
			stat_low_r <= stat_low_nxt;
		end
	end

	// Decoded bit is launched on the rising edge for the far party
	always_ff @(posedge rx_link_clk_i) begin
		if (link_rst) begin
			data_r <= DATA_RST;
		end else if (take_bit) begin
			data_r <= dec_bit_i;
		end
	end

	// Falling-edge copies hold activity and status low into the idle cycle
	always_ff @(negedge rx_link_clk_i) begin
		if (link_rst) begin
			act_neg_r <= ACT_RST;
			stat_low_neg_r <= STAT_LOW_RST;
		end else begin
			act_neg_r <= act_r;
			stat_low_neg_r <= stat_low_r;
		end
	end

	// Cycle start event crosses to the core clock as a toggle
	always_ff @(posedge rx_link_clk_i) begin
		if (link_rst) begin
			cyc_tgl_r <= 1'b0;
		end else if (dec_cycle_start_i) begin
			cyc_tgl_r <= !cyc_tgl_r;
		end
	end

	// ---------------------------------------------------------------
	// Outputs toward the host sublayer
	// ---------------------------------------------------------------
	// Rises with the rising edge, falls only at the following falling edge
	assign receive_activity_o = act_r || act_neg_r;
	assign receive_status_flag_o = !(stat_low_r || stat_low_neg_r);
	assign receive_check_select_o = chk_r;
	assign receive_data_line_o = data_r;
	// Recovered clock passes through so it tracks received timing
	assign receive_clock_o = rx_link_clk_i;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	idle_outputs_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_CRC_IDLE) && $past(state_r == ST_CRC_IDLE)
		|-> !receive_activity_o && receive_check_select_o
	) else $error("checksum idle outputs wrong");

	frame_start_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_CRC_IDLE) && dec_valid_i && dec_frame_start_i
		|=> receive_activity_o && !receive_check_select_o
			&& (receive_data_line_o == $past(dec_bit_i))
	) else $error("data frame start not delivered");

	status_start_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_CRC_IDLE) && dec_valid_i && dec_status_start_i && !dec_frame_start_i
		|=> receive_activity_o && !receive_status_flag_o
			&& (receive_data_line_o == $past(dec_bit_i))
	) else $error("status start not delivered");

	data_shift_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_DATA_SEQ) && dec_valid_i && !at_bnd
		|=> receive_activity_o && (receive_data_line_o == $past(dec_bit_i))
	) else $error("data bit not shifted out");

	data_pause_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_DATA_SEQ) && at_bnd && !dec_valid_i
		|=> (state_r == ST_DATA_IDLE) && !receive_activity_o
	) else $error("activity not dropped after data octet");

	data_idle_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_DATA_IDLE) && $past(state_r == ST_DATA_IDLE)
		|-> !receive_activity_o && !receive_check_select_o
	) else $error("data idle outputs wrong");

	check_start_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_DATA_IDLE) && dec_valid_i && dec_check_start_i
		|=> receive_activity_o && receive_check_select_o
			&& (receive_data_line_o == $past(dec_bit_i))
	) else $error("check sequence start wrong");

	octet_bound_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		!$stable(state_r) && !$past(link_rst) |-> $past(bit_cnt_r) == BIT_CNT_BND
	) else $error("state changed inside an octet");

	status_end_a: assert property (
		@(posedge rx_link_clk_i) disable iff (link_rst)
		(state_r == ST_CRC_STATUS) && at_bnd && !dec_valid_i && dec_frame_end_i
		|=> !receive_activity_o && receive_status_flag_o
	) else $error("status end not signalled");

	reset_ind_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		req_rise && !reset_indication_o |=> reset_indication_o [*8]
	) else $error("reset indication missing after request");

	cycle_sel_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		cyc_evt && receive_cycle_select_o |=> !receive_cycle_select_o
	) else $error("cycle select did not fall");

endmodule
`default_nettype wire

// ==== rsf_pkg.sv ====
// Shared constants for the serial frame receive delivery block.
// Assumes a 125 MHz core clock and a recovered bit clock from the line decoder.
package rsf_pkg;

	// ---------------------------------------------------------------
	// Core clock and reset timing
	// ---------------------------------------------------------------
	localparam int CORE_CLK_NS = 8;
	localparam int RST_SHORT_NS = 1000;
	localparam int RST_LONG_NS = 100000;
	localparam int CYC_LOW_NS = 200;
	localparam int RST_SHORT_CYC = (RST_SHORT_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int RST_LONG_CYC = (RST_LONG_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int CYC_LOW_CYC = (CYC_LOW_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
	localparam int TMR_W = 17;

	// ---------------------------------------------------------------
	// Octet framing
	// ---------------------------------------------------------------
	localparam int BIT_CNT_W = 3;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_FIRST = 3'h1;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_BND = 3'h0;

	// ---------------------------------------------------------------
	// Output reset levels
	// ---------------------------------------------------------------
	localparam logic ACT_RST = 1'b0;
	localparam logic CHK_SEL_RST = 1'b1;
	localparam logic STAT_LOW_RST = 1'b0;
	localparam logic CYC_SEL_IDLE = 1'b1;
	localparam logic DATA_RST = 1'b0;

	// Delivery states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_CRC_IDLE = 3'h0,
		ST_DATA_SEQ = 3'h1,
		ST_DATA_IDLE = 3'h3,
		ST_CRC_DATA = 3'h2,
		ST_CRC_STATUS = 3'h6,
		ST_STATUS_IDLE = 3'h7
	} rsf_state_t;

endpackage

// ==== rsf_tmr_if.sv ====
// Start/length/busy group between the delivery top and its pulse timers.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface rsf_tmr_if;
	import rsf_pkg::*;
	logic start;
	logic [TMR_W-1:0] len;
	logic busy;
	modport ctl (output start, output len, input busy);
	modport tmr (input start, input len, output busy);
endinterface
`default_nettype wire

// ==== rsf_sync.sv ====
// Two flip-flop level synchroniser.
// Assumes d_i is a level from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none
module rsf_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ==== rsf_pulse_timer.sv ====
// Retriggerable-free pulse timer: busy for len cycles after a start.
// Assumes start and len come from core-clock logic; starts while busy are ignored.
`timescale 1ns/1ps
`default_nettype none
module rsf_pulse_timer
	import rsf_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	rsf_tmr_if.tmr ctl
);
	logic [TMR_W-1:0] cnt_r;
	logic [TMR_W-1:0] cnt_nxt;
	logic load;

	assign load = ctl.start && (cnt_r == '0);
	assign cnt_nxt = load ? ctl.len : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
	assign ctl.busy = (cnt_r != '0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// ==== rsf_host_model.sv ====
// Host sublayer model: samples delivered bits and raises reset requests.
// Assumes receive_clock_i is the design's pass-through link clock.
`timescale 1ns/1ps
`default_nettype none
module rsf_host_model (
	input wire logic core_clk_i,
	input wire logic receive_clock_i,
	input wire logic receive_data_line_i,
	input wire logic receive_activity_i,
	output logic reset_request_out_o,
	output logic [7:0] octet_o
);
	logic [7:0] sh_r = 8'h00;
	int n_r = 0;
	initial begin
		reset_request_out_o = 1'b0;
		octet_o = 8'h00;
	end
	// Bits taken on the rising edge, only while activity is high
	always @(posedge receive_clock_i) begin
		if (!receive_activity_i) begin
			n_r = 0;
		end else begin
			sh_r = {receive_data_line_i, sh_r[7:1]};
			n_r++;
			if (n_r == 8) begin
				octet_o = sh_r;
				n_r = 0;
			end
		end
	end
	// Request held for n core cycles, changed just after an edge
	task automatic req(input int n);
		@(posedge core_clk_i);
		#2;
		reset_request_out_o = 1'b1;
		repeat (n) @(posedge core_clk_i);
		#2;
		reset_request_out_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Testbench: drives the decoder side, watches the host pins.
// Assumes rsf_pkg, the design files and rsf_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb
	import rsf_pkg::*;
();
	localparam int LONG_N = 40;
	logic clk = 0, lk = 0, lk_en = 1, rst = 1;
	logic v = 0, b = 0, fs = 0, cs = 0, ss = 0, fe = 0, cy = 0, lsel = 0;
	wire logic rclk, rdat, ract, rcsel, rsf, rind, rcyc, rreq;
	wire logic [7:0] hoct;
	int err_total = 0;
	int comparisons = 0;
	int n;
	always #4 clk = ~clk;
	initial begin
		#3;
		forever begin
			#40;
			if (lk_en) lk = ~lk;
		end
	end
	rsf_rx_deliver #(.RST_LONG_CYCLES(LONG_N)) i_dut (.core_clk_i(clk), .rst_i(rst),
		.rx_link_clk_i(lk), .dec_bit_i(b), .dec_valid_i(v), .dec_frame_start_i(fs),
		.dec_check_start_i(cs), .dec_status_start_i(ss), .dec_frame_end_i(fe),
		.dec_cycle_start_i(cy), .reset_request_out_i(rreq), .reset_long_sel_i(lsel),
		.receive_clock_o(rclk), .receive_data_line_o(rdat), .receive_activity_o(ract),
		.receive_check_select_o(rcsel), .receive_status_flag_o(rsf),
		.reset_indication_o(rind), .receive_cycle_select_o(rcyc));
	rsf_host_model i_host (.core_clk_i(clk), .receive_clock_i(rclk),
		.receive_data_line_i(rdat), .receive_activity_i(ract),
		.reset_request_out_o(rreq), .octet_o(hoct));
	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic drv(input logic dv, db, dfs, dcs, dss, dfe);
		@(posedge lk);
		#2;
		v = dv; b = db; fs = dfs; cs = dcs; ss = dss; fe = dfe;
	endtask
	task automatic oct(input logic [7:0] d, input logic f, c, s, ec, es);
		for (int i = 0; i < 8; i++) begin
			drv(1'b1, d[i], i == 0 && f, i == 0 && c, i == 0 && s, 1'b0);
			if (i > 0) begin
				chk("activity", ract, 1'b1);
				chk("receive clock", rclk, 1'b1);
				chk("check_select", rcsel, ec);
				chk("status_flag", rsf, es);
				chk("data", rdat, d[i-1]);
			end
		end
	endtask
	task automatic pz(input logic e);
		drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, e);
		@(posedge lk);
		#2;
		chk("activity before fall", ract, 1'b1);
		@(negedge lk);
		#1;
		chk("activity at fall", ract, 1'b0);
	endtask
	task automatic hold(input bit ind, output int k);
		int t;
		k = 0;
		@(negedge clk);
		for (t = 0; t < 20 && !(ind ? rind : !rcyc); t++) @(negedge clk);
		while ((ind ? rind : !rcyc) && k < 20000) begin
			@(negedge clk);
			k++;
		end
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_frame();
		oct(8'hA5, 1, 0, 0, 0, 1);
		oct(8'h3C, 0, 0, 0, 0, 1);
		pz(0);
		chk("host octet", hoct, 8'h3C);
		chk("idle check_select", rcsel, 1'b0);
		oct(8'h5A, 0, 0, 0, 0, 1);
		pz(0);
		oct(8'hC3, 0, 1, 0, 1, 1);
		pz(0);
		chk("host octet", hoct, 8'hC3);
		oct(8'h96, 0, 1, 0, 1, 1);
		oct(8'h81, 0, 0, 1, 1, 0);
		pz(0);
		oct(8'h7E, 0, 0, 0, 1, 0);
		pz(1);
		chk("end status_flag", rsf, 1'b1);
		chk("end check_select", rcsel, 1'b1);
		chk("host octet", hoct, 8'h7E);
		$display("test frame done");
	endtask
	task automatic t_stat();
		lk_en = 0;
		#500;
		lk_en = 1;
		repeat (2) @(posedge lk);
		oct(8'hE7, 0, 0, 1, 1, 0);
		pz(1);
		chk("status_flag", rsf, 1'b1);
		chk("host octet", hoct, 8'hE7);
		oct(8'h18, 1, 0, 0, 0, 1);
		oct(8'h24, 0, 1, 0, 1, 1);
		pz(0);
		chk("host octet", hoct, 8'h24);
		$display("test status done");
	endtask
	task automatic t_stall();
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
				@(negedge lk);
				@(negedge lk);
				#1;
				chk("stall activity", ract, 1'b1);
			end
			drv(1'b1, i[0], i == 0, 1'b0, 1'b0, 1'b0);
		end
		pz(0);
		drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		drv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge lk);
		#2;
		chk("idle activity", ract, 1'b0);
		chk("idle check_select", rcsel, 1'b1);
		$display("test stall done");
	endtask
	task automatic t_cyc();
		@(posedge lk);
		#2;
		cy = 1;
		@(posedge lk);
		#2;
		cy = 0;
		hold(0, n);
		chk("cycle select low", n, CYC_LOW_CYC);
		$display("test cycle done");
	endtask
	task automatic t_rst(input logic lng, input int e);
		@(posedge clk);
		#2;
		lsel = lng;
		i_host.req(3);
		hold(1, n);
		chk("reset length", n, e);
		repeat (6) @(posedge lk);
		#2;
		chk("after reset check_select", rcsel, 1'b1);
		$display("test reset done");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#600000;
		err_total++;
		$display("ERROR watchdog expected finish seen hang");
		test_done();
	end
	initial begin
		repeat (4) @(posedge clk);
		#2;
		rst = 0;
		repeat (20) @(posedge lk);
		#2;
		chk("reset activity", ract, 1'b0);
		chk("reset check_select", rcsel, 1'b1);
		chk("reset cycle_select", rcyc, 1'b1);
		chk("reset indication", rind, 1'b0);
		t_frame();
		t_stat();
		t_stall();
		t_cyc();
		t_rst(1'b0, RST_SHORT_CYC);
		t_rst(1'b1, LONG_N);
		test_done();
	end
endmodule
`default_nettype wire
